/* hdl/aux_io_consts.svh */
// Purpose: constants for the auxiliary i/o smi and wake register bank
// Assumes: apb byte addresses are the printed offsets times four
// Notes: printed offsets are not word aligned, so they are indices
`ifndef AUX_IO_CONSTS_SVH
`define AUX_IO_CONSTS_SVH
`define IDX_EN_A      8'hb4
`define IDX_EN_B      8'hb5
`define IDX_ST_A      8'hb6
`define IDX_ST_B      8'hb7
`define IDX_STBY_RSVD 8'hb8
`define IDX_PIN_SEL   8'hc0
`define IDX_FORCE     8'hc1
`define IDX_FD_RATE   8'hc2
`define IDX_UA_FIFO   8'hc3
`define IDX_UB_FIFO   8'hc4
`define IDX_WAKE_CTL  8'hc5
`define IDX_WAKE_ST   8'hc6
`define IDX_IR_OPT    8'hc7
`define RST_PIN_SEL   8'h02
`define RST_FORCE     8'h03
`define RST_FD_SYNC   3'h7
`define RST_IR_SYNC   3'h6
`define MASK_EN_A     8'h9e
`define MASK_EN_B     8'h17
`define BIT_SERIAL    6
`define BIT_IR_EDGE   2
`define BIT_IR_SEL    6
`define BIT_CHG       7
`define MASK_RATE     8'hdf
`define MASK_FIFO     8'hcf
`endif

/* hdl/aux_io_pkg.sv */
// Purpose: shared types for the auxiliary i/o bank
// Assumes: nothing
// Notes: none
package aux_io_pkg;
  typedef enum logic [1:0] {apb_idle, apb_setup, apb_access} apb_phase_e;
  typedef logic [7:0] reg8_t;
endpackage

/* hdl/sync2.sv */
// Purpose: two flop synchroniser for pin inputs
// Assumes: one clock
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [W-1:0] rst_val,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // reset value loaded after release, reset takes constants only
  logic         primed;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta   <= '0;
      q      <= '0;
      primed <= 1'b0;
    end else begin
      primed <= 1'b1;
      meta   <= d;
      q      <= primed ? meta : rst_val;
    end
  end
endmodule

/* hdl/edge_flag.sv */
// Purpose: sticky flag set by any edge, cleared by request
// Assumes: input already synchronised
// Notes: set beats clear in the same cycle
`timescale 1ns/1ps
module edge_flag (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic level,
  input  wire logic clr,
  output logic      flag
);
  logic       last;
  // two settling edges: the synchroniser shows its reset value first
  logic [1:0] primed;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      last   <= 1'b0;
      primed <= 2'b00;
      flag   <= 1'b0;
    end else begin
      last   <= level;
      primed <= {primed[0], 1'b1};
      if (primed[1] && (level != last)) begin
        flag <= 1'b1;
      end else if (clr) begin
        flag <= 1'b0;
      end
    end
  end
endmodule

/* hdl/aux_io_smi_pme_regs.sv */
// Purpose: smi gating, status, disk change, shadows and wake enable
// Assumes: apb slave, one cycle access wait state; pins synchronised here
// Notes: standby reset stby_rstn keeps wake enable across main resets
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "aux_io_consts.svh"
module aux_io_smi_pme_regs
  import aux_io_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        stby_rstn,
  input  wire logic [9:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        par_port_req,
  input  wire logic        uart_a_req,
  input  wire logic        uart_b_req,
  input  wire logic        floppy_req,
  input  wire logic        watchdog_req,
  input  wire logic        mouse_req,
  input  wire logic        keyboard_req,
  input  wire logic        kbc_port_line,
  input  wire logic        uart_b_rx,
  input  wire logic        alt_infrared_rx,
  input  wire logic        head_step_n,
  input  wire logic        drive_select_zero_n,
  input  wire logic        media_change_pin_n,
  input  wire logic [7:0]  floppy_rate_in,
  input  wire logic [7:0]  uart_a_fifo_in,
  input  wire logic [7:0]  uart_b_fifo_in,
  input  wire logic        wake_event_req,
  output logic             group_mgmt_irq_n,
  output logic             smi_serial_frame,
  output logic             wake_event_n,
  output logic             media_change_bit
);
  // all pin inputs sampled through two flops
  logic [7:0] s_misc;
  logic [2:0] s_fd;
  logic [7:0] s_rate;
  logic [7:0] s_ua;
  logic [7:0] s_ub;
  logic       s_irb;
  logic       s_ira;
  logic       s_wake;

  sync2 #(.W(8)) u_sync_misc (
    .clock   (clock),
    .rstn    (rstn),
    .rst_val (8'h00),
    .d       ({watchdog_req, mouse_req, keyboard_req, kbc_port_line,
                floppy_req, uart_a_req, uart_b_req, par_port_req}),
    .q       (s_misc)
  );
  sync2 #(.W(3)) u_sync_fd (
    .clock   (clock),
    .rstn    (rstn),
    .rst_val (`RST_FD_SYNC),
    .d       ({head_step_n, drive_select_zero_n, media_change_pin_n}),
    .q       (s_fd)
  );
  sync2 #(.W(8)) u_sync_rate (
    .clock   (clock),
    .rstn    (rstn),
    .rst_val (8'h00),
    .d       (floppy_rate_in),
    .q       (s_rate)
  );
  sync2 #(.W(8)) u_sync_ua (
    .clock   (clock),
    .rstn    (rstn),
    .rst_val (8'h00),
    .d       (uart_a_fifo_in),
    .q       (s_ua)
  );
  sync2 #(.W(8)) u_sync_ub (
    .clock   (clock),
    .rstn    (rstn),
    .rst_val (8'h00),
    .d       (uart_b_fifo_in),
    .q       (s_ub)
  );
  sync2 #(.W(3)) u_sync_ir (
    .clock   (clock),
    .rstn    (rstn),
    .rst_val (`RST_IR_SYNC),
    .d       ({uart_b_rx, alt_infrared_rx, wake_event_req}),
    .q       ({s_irb, s_ira, s_wake})
  );

  logic par_port_req_flag;
  logic uart_b_req_flag;
  logic uart_a_req_flag;
  logic floppy_req_flag;
  logic watchdog_req_flag;
  logic mouse_req_flag;
  logic keyboard_req_flag;
  logic kbc_port_line_flag;
  assign {watchdog_req_flag, mouse_req_flag, keyboard_req_flag,
          kbc_port_line_flag, floppy_req_flag, uart_a_req_flag,
          uart_b_req_flag, par_port_req_flag} = s_misc;

  reg8_t smi_source_enable_a;
  reg8_t smi_source_enable_b;
  reg8_t pin_function_select;
  reg8_t ir_option;
  reg8_t standby_reserved;
  logic  forced_media_change;
  logic  wake_out_enable;
  logic  wake_pending_flag;
  logic  infrared_edge_flag;
  logic  ir_clr;

  // ir source mux ahead of edge detect
  logic ir_level;
  assign ir_level = ir_option[`BIT_IR_SEL] ? s_ira : s_irb;

  edge_flag u_ir_edge (
    .clock (clock),
    .rstn  (rstn),
    .level (ir_level),
    .clr   (ir_clr),
    .flag  (infrared_edge_flag)
  );

  // status a live view, cleared at source
  reg8_t smi_source_status_a;
  reg8_t smi_source_status_b;
  assign smi_source_status_a = {watchdog_req_flag, 2'b00, floppy_req_flag,
                                uart_a_req_flag, uart_b_req_flag,
                                par_port_req_flag, 1'b0};
  // status b live view plus ir edge
  assign smi_source_status_b = {3'b000, kbc_port_line_flag, 1'b0,
                                infrared_edge_flag, keyboard_req_flag,
                                mouse_req_flag};

  // apb decode, word index from byte address
  logic [7:0] idx;
  logic       wr_take;
  logic       rd_take;
  assign idx     = paddr[9:2];
  // writes land on the completing edge, where the master sees pready
  assign wr_take = psel && penable && pwrite && pready;
  assign rd_take = psel && penable && !pwrite && !pready;

  function automatic logic mapped(input logic [7:0] i);
    case (i)
      `IDX_EN_A, `IDX_EN_B, `IDX_ST_A, `IDX_ST_B, `IDX_STBY_RSVD,
      `IDX_PIN_SEL, `IDX_FORCE, `IDX_FD_RATE, `IDX_UA_FIFO,
      `IDX_UB_FIFO, `IDX_WAKE_CTL, `IDX_WAKE_ST, `IDX_IR_OPT:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  endfunction

  logic wr_lane;
  assign wr_lane = wr_take && pstrb[0];

  // main supply registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      smi_source_enable_a <= 8'h00;
      smi_source_enable_b <= 8'h00;
      pin_function_select <= `RST_PIN_SEL;
      ir_option           <= 8'h00;
    end else if (wr_lane) begin
      case (idx)
        `IDX_EN_A:    smi_source_enable_a <= pwdata[7:0] & `MASK_EN_A;
        `IDX_EN_B:    smi_source_enable_b <= pwdata[7:0] &
                        (`MASK_EN_B | (8'h01 << `BIT_SERIAL));
        `IDX_PIN_SEL: pin_function_select <= pwdata[7:0] & `RST_PIN_SEL | 
                        (pwdata[7:0] & 8'h08);
        `IDX_IR_OPT:  ir_option <= pwdata[7:0] & (8'h01 << `BIT_IR_SEL);
        default:      ir_option <= ir_option;
      endcase
    end
  end

  // step edge while drive 0 selected
  logic step_last;
  logic step_fall;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // synchroniser reads low in reset, so idle low avoids a false step
      step_last <= 1'b0;
    end else begin
      step_last <= s_fd[2];
    end
  end
  assign step_fall = step_last && !s_fd[2];

  // force latch: software set wins over hardware clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      forced_media_change <= 1'(`RST_FORCE);
    end else if (wr_lane && idx == `IDX_FORCE && pwdata[0]) begin
      forced_media_change <= 1'b1;
    end else if (step_fall && !s_fd[1]) begin
      forced_media_change <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      media_change_bit <= 1'b1;
    end else begin
      media_change_bit <= (s_fd[1] & forced_media_change) | s_fd[0];
    end
  end

  always_ff @(posedge clock or negedge stby_rstn) begin
    if (!stby_rstn) begin
      wake_out_enable  <= 1'b0;
      standby_reserved <= 8'h00;
    end else if (wr_lane && idx == `IDX_WAKE_CTL) begin
      wake_out_enable <= pwdata[0];
    end
  end

  // pending flag; event beats write-one clear
  always_ff @(posedge clock or negedge stby_rstn) begin
    if (!stby_rstn) begin
      wake_pending_flag <= 1'b0;
    end else if (s_wake) begin
      wake_pending_flag <= 1'b1;
    end else if (wr_lane && idx == `IDX_WAKE_ST && pwdata[0]) begin
      wake_pending_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge stby_rstn) begin
    if (!stby_rstn) begin
      wake_event_n <= 1'b1;
    end else begin
      wake_event_n <= !(wake_pending_flag && wake_out_enable);
    end
  end

  logic smi_any;
  assign smi_any = |(smi_source_status_a & smi_source_enable_a) |
                   |(smi_source_status_b & smi_source_enable_b & `MASK_EN_B);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      group_mgmt_irq_n <= 1'b1;
      smi_serial_frame <= 1'b0;
    end else begin
      group_mgmt_irq_n <= !smi_any;
      smi_serial_frame <= smi_any && smi_source_enable_b[`BIT_SERIAL];
    end
  end

  // read mux; live views
  reg8_t rd_val;
  always_comb begin
    rd_val = 8'h00;
    case (idx)
      `IDX_EN_A:      rd_val = smi_source_enable_a;
      `IDX_EN_B:      rd_val = smi_source_enable_b;
      `IDX_ST_A:      rd_val = smi_source_status_a;
      `IDX_ST_B:      rd_val = smi_source_status_b;
      `IDX_STBY_RSVD: rd_val = standby_reserved;
      `IDX_PIN_SEL:   rd_val = pin_function_select;
      `IDX_FORCE:     rd_val = {7'h01, forced_media_change};
      `IDX_FD_RATE:   rd_val = s_rate & `MASK_RATE;
      `IDX_UA_FIFO:   rd_val = s_ua & `MASK_FIFO;
      `IDX_UB_FIFO:   rd_val = s_ub & `MASK_FIFO;
      `IDX_WAKE_CTL:  rd_val = {7'h00, wake_out_enable};
      `IDX_WAKE_ST:   rd_val = {7'h00, wake_pending_flag};
      `IDX_IR_OPT:    rd_val = ir_option;
      default:        rd_val = 8'h00;
    endcase
  end

  // read of status b clears ir flag
  assign ir_clr = rd_take && idx == `IDX_ST_B;

  // one wait state: pready high on second access cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped(idx);
      if (rd_take) begin
        prdata <= {24'h00_0000, rd_val};
      end
    end
  end

  AST_IR_CLR: assert property (@(posedge clock) disable iff (!rstn)
    (ir_clr && !(ir_level != $past(ir_level))) |=> !infrared_edge_flag)
    else $error("ir flag not cleared by read");
  AST_SERIAL: assert property (@(posedge clock) disable iff (!rstn)
    smi_serial_frame |-> !group_mgmt_irq_n)
    else $error("serial frame without smi");
  AST_SERIAL_ON: assert property (@(posedge clock) disable iff (!rstn)
    (smi_any && smi_source_enable_b[`BIT_SERIAL]) |=> smi_serial_frame)
    else $error("serial frame missing");
  AST_SMI: assert property (@(posedge clock) disable iff (!rstn)
    smi_any |=> !group_mgmt_irq_n)
    else $error("smi not asserted");
  AST_WAKE: assert property (@(posedge clock) disable iff (!stby_rstn)
    !wake_out_enable |=> wake_event_n)
    else $error("wake asserted while disabled");
  AST_WK_ON: assert property (@(posedge clock) disable iff (!stby_rstn)
    (wake_pending_flag && wake_out_enable) |=> !wake_event_n)
    else $error("wake not asserted while enabled");
  AST_PEND: assert property (@(posedge clock) disable iff (!stby_rstn)
    s_wake |=> wake_pending_flag)
    else $error("pending flag missed");
  AST_FORCE: assert property (@(posedge clock) disable iff (!rstn)
    (wr_lane && idx == `IDX_FORCE && pwdata[0]) |=> forced_media_change)
    else $error("force latch not set");
  AST_STEP: assert property (@(posedge clock) disable iff (!rstn)
    (step_fall && !s_fd[1] && !wr_lane) |=> !forced_media_change)
    else $error("force latch not cleared");
  // first edge after release is skipped, since its past values were seen in reset
  AST_CHG: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn) |->
      media_change_bit == $past((s_fd[1] & forced_media_change) | s_fd[0]))
    else $error("media change wrong");
endmodule

/* bench/host_smi_model.sv */
// Purpose: host chipset input stage for group smi and serial frame
// Assumes: smi is an active low level, frame a high level
// Notes: no serial irq slot timing, only the reported level
`timescale 1ns/1ps
module host_smi_model (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic group_mgmt_irq_n,
  input  wire logic smi_serial_frame,
  output logic      smi_pending,
  output logic      frame_seen
);
  // registered like a chipset input, so one cycle late
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      smi_pending <= 1'b0;
      frame_seen  <= 1'b0;
    end else begin
      smi_pending <= ~group_mgmt_irq_n;
      frame_seen  <= smi_serial_frame;
    end
  end
endmodule

/* bench/test_aux_io_smi_pme_regs.sv */
// Purpose: self-checking bench for the smi and wake register bank
// Assumes: apb answer waited for, pins settle within six cycles
// Notes: all stimulus by non-blocking assignment after a rising edge
`timescale 1ns/1ps
`include "aux_io_consts.svh"
module test_aux_io_smi_pme_regs import aux_io_pkg::*;;
  logic        clock = 0, rstn = 0, stby_rstn = 0;
  logic [9:0]  paddr = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, smi_pending, frame_seen;
  reg8_t       sa = 0, sb = 0, frate = 0, fa = 0, fb = 0, d;
  logic        uart_b_rx = 1, alt_infrared_rx = 1, head_step_n = 1;
  logic        drive_select_zero_n = 1, media_change_pin_n = 1;
  logic        wake_event_req = 0, e;
  logic        group_mgmt_irq_n, smi_serial_frame;
  logic        wake_event_n, media_change_bit;
  int          error_cnt = 0, check_count = 0;
  always #12.5 clock = ~clock;
  aux_io_smi_pme_regs aux_io_smi_pme_regs_inst (.clock, .rstn,
    .stby_rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .par_port_req(sa[1]),
    .uart_b_req(sa[2]), .uart_a_req(sa[3]), .floppy_req(sa[4]),
    .watchdog_req(sa[7]), .mouse_req(sb[0]), .keyboard_req(sb[1]),
    .kbc_port_line(sb[4]), .uart_b_rx, .alt_infrared_rx, .head_step_n,
    .drive_select_zero_n, .media_change_pin_n, .floppy_rate_in(frate),
    .uart_a_fifo_in(fa), .uart_b_fifo_in(fb), .wake_event_req,
    .group_mgmt_irq_n, .smi_serial_frame, .wake_event_n,
    .media_change_bit);
  host_smi_model host_smi_model_inst (.clock, .rstn, .group_mgmt_irq_n,
    .smi_serial_frame, .smi_pending, .frame_seen);
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string n, input reg8_t x, input reg8_t g);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input reg8_t i, input reg8_t wd);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      print_verdict();
    end
    d = prdata[7:0];
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic rd(input reg8_t i, input reg8_t x, input string n);
    apb(1'b0, i, 8'h00);
    chk(n, x, d);
  endtask
  task automatic wr(input reg8_t i, input reg8_t v);
    apb(1'b1, i, v);
  endtask
  // pins pass a two flop sync plus an output flop
  task automatic wt();
    repeat (6) @(posedge clock);
  endtask
  task automatic t_regs();
    rd(`IDX_EN_A, 8'h00, "en_a");
    rd(`IDX_EN_B, 8'h00, "en_b");
    rd(`IDX_PIN_SEL, `RST_PIN_SEL, "pinsel");
    rd(`IDX_WAKE_CTL, 8'h00, "wake_ctl");
    wr(`IDX_EN_A, 8'hff);
    rd(`IDX_EN_A, `MASK_EN_A, "en_a rw");
    wr(`IDX_EN_A, 8'h00);
    pstrb <= 4'he;
    wr(`IDX_EN_A, 8'hff);
    pstrb <= 4'hf;
    rd(`IDX_EN_A, 8'h00, "en_a strb");
    rd(8'h10, 8'h00, "unmapped");
    chk("slverr", 8'h01, {7'h00, e});
  endtask
  task automatic t_smi(input logic b, input int i);
    reg8_t m, ix, st;
    m = 8'h01 << i;
    ix = b ? `IDX_EN_B : `IDX_EN_A;
    st = b ? `IDX_ST_B : `IDX_ST_A;
    if (b) sb <= m;
    else sa <= m;
    wt();
    rd(st, m, "status");
    chk("smi off", 8'h01, {7'h00, group_mgmt_irq_n});
    wr(ix, ~m & (b ? `MASK_EN_B : `MASK_EN_A));
    wt();
    chk("smi other", 8'h01, {7'h00, group_mgmt_irq_n});
    wr(ix, m | (b ? 8'h40 : 8'h00));
    wt();
    chk("smi on", 8'h00, {7'h00, group_mgmt_irq_n});
    chk("host", 8'h01, {7'h00, smi_pending});
    chk("frame", {7'h00, b}, {7'h00, frame_seen});
    if (b) sb <= 0;
    else sa <= 0;
    wt();
    chk("smi rel", 8'h01, {7'h00, group_mgmt_irq_n});
    chk("frame rel", 8'h00, {7'h00, frame_seen});
    rd(st, 8'h00, "st clr");
    wr(ix, 8'h00);
  endtask
  task automatic t_ir();
    wr(`IDX_EN_B, 8'h04);
    alt_infrared_rx <= 0;
    wt();
    rd(`IDX_ST_B, 8'h00, "ir unsel");
    sb <= 8'h01;
    uart_b_rx <= 0;
    wt();
    chk("ir smi", 8'h00, {7'h00, group_mgmt_irq_n});
    rd(`IDX_ST_B, 8'h05, "ir edge");
    rd(`IDX_ST_B, 8'h01, "ir rdclr");
    sb <= 8'h00;
    wr(`IDX_IR_OPT, 8'h40);
    uart_b_rx <= 1;
    wt();
    rd(`IDX_ST_B, 8'h00, "ir alt sel");
    alt_infrared_rx <= 1;
    wt();
    rd(`IDX_ST_B, 8'h04, "ir alt");
    wt();
    chk("ir rel", 8'h01, {7'h00, group_mgmt_irq_n});
    wr(`IDX_EN_B, 8'h00);
    wr(`IDX_IR_OPT, 8'h00);
  endtask
  task automatic t_disk();
    media_change_pin_n <= 0;
    wt();
    chk("chg rst", 8'h01, {7'h00, media_change_bit});
    drive_select_zero_n <= 0;
    head_step_n <= 0;
    wt();
    head_step_n <= 1;
    drive_select_zero_n <= 1;
    wt();
    rd(`IDX_FORCE, 8'h02, "force step");
    chk("chg off", 8'h00, {7'h00, media_change_bit});
    wr(`IDX_FORCE, 8'h00);
    rd(`IDX_FORCE, 8'h02, "force w0");
    wr(`IDX_FORCE, 8'h01);
    wt();
    rd(`IDX_FORCE, 8'h03, "force w1");
    chk("chg set", 8'h01, {7'h00, media_change_bit});
    wr(`IDX_FORCE, 8'h00);
    rd(`IDX_FORCE, 8'h03, "force keep");
    drive_select_zero_n <= 0;
    wt();
    chk("chg ds", 8'h00, {7'h00, media_change_bit});
    media_change_pin_n <= 1;
    wt();
    chk("chg pin", 8'h01, {7'h00, media_change_bit});
    drive_select_zero_n <= 1;
  endtask
  task automatic t_shadow();
    frate <= 8'hff;
    fa <= 8'hff;
    fb <= 8'h5a;
    wt();
    rd(`IDX_FD_RATE, `MASK_RATE, "rate");
    rd(`IDX_UA_FIFO, `MASK_FIFO, "fifo a");
    rd(`IDX_UB_FIFO, 8'h4a, "fifo b");
    frate <= 8'h20;
    wt();
    rd(`IDX_FD_RATE, 8'h00, "rate rsvd");
  endtask
  task automatic t_wake();
    wake_event_req <= 1;
    wt();
    chk("wake off", 8'h01, {7'h00, wake_event_n});
    rd(`IDX_WAKE_ST, 8'h01, "wake st");
    wr(`IDX_WAKE_CTL, 8'h01);
    wt();
    chk("wake on", 8'h00, {7'h00, wake_event_n});
    rstn <= 0;
    repeat (2) @(posedge clock);
    rstn <= 1;
    wt();
    rd(`IDX_WAKE_CTL, 8'h01, "wake main");
    chk("wake kept", 8'h00, {7'h00, wake_event_n});
    stby_rstn <= 0;
    repeat (2) @(posedge clock);
    stby_rstn <= 1;
    wt();
    rd(`IDX_WAKE_CTL, 8'h00, "wake stby");
    chk("wake n", 8'h01, {7'h00, wake_event_n});
    wake_event_req <= 0;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1;
    stby_rstn <= 1;
    wt();
    t_regs();
    foreach (sa[i]) if (`MASK_EN_A >> i & 1) t_smi(1'b0, i);
    foreach (sb[i]) if (8'h13 >> i & 1) t_smi(1'b1, i);
    t_ir();
    t_disk();
    t_shadow();
    t_wake();
    print_verdict();
  end
  // guard against a hang outside the bus waits
  initial begin
    #2000000;
    error_cnt++;
    print_verdict();
  end
endmodule
